// file: hw/trap_cfg.svh
// offsets, field positions, reset values and counts of the trap control block
`ifndef TRAP_CFG_SVH
`define TRAP_CFG_SVH

// byte offsets within the slave window
`define TCS1_OFFSET 12'h000
`define IRQ_STATUS_OFFSET 12'h004
`define IRQ_MASK_OFFSET 12'h008
`define ADDR_DECODE_W 12

// field positions of trap_control_status_1
`define ACC_A_EN_BIT 10
`define ACC_B_EN_BIT 9
`define CAT_EN_BIT 8
`define SHIFT_ACC_BIT 7
`define DIV_ZERO_BIT 6
`define DMA_ERR_BIT 5
`define ARITH_ERR_BIT 4
`define ADDR_ERR_BIT 3
`define STACK_ERR_BIT 2
`define OSC_FAIL_BIT 1
`define UNUSED_BIT 0

// flag field bounds, shared by the status and mask registers
`define FLAG_MSB 7
`define FLAG_LSB 1
`define FLAG_W 7

// reset values
`define TRAP_EN_RESET 3'h0
`define FLAGS_RESET 7'h00
`define IRQ_MASK_RESET 7'h00
`define HRDATA_RESET 32'h00000000

`endif

// file: hw/trap_pkg.sv
// types shared by the trap control block
package trap_pkg;

    // one-cycle trap causes from detection logic on the same clock
    typedef struct packed {
        logic acc_a_ovf;
        logic acc_b_ovf;
        logic acc_a_cat_ovf;
        logic acc_b_cat_ovf;
        logic shift_acc_err;
        logic div_zero_err;
        logic dma_err;
        logic addr_err;
        logic stack_err;
    } trap_evt_s;

    // trap enables as held in trap_control_status_1
    typedef struct packed {
        logic acc_a_overflow_trap_en;
        logic acc_b_overflow_trap_en;
        logic catastrophic_overflow_trap_en;
    } trap_en_s;

    typedef logic [15:0] reg16_t;

endpackage : trap_pkg

// file: hw/pin_sync3.sv
// three-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] s2,
    output logic [W-1:0] s3
);
    logic [W-1:0] s1;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (ce) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end
endmodule : pin_sync3

// file: hw/sticky_bits.sv
// sticky flag bank: set wins over clear in the same cycle
`timescale 1ns/10ps
module sticky_bits #(
    parameter int W = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= (q & ~clr) | set;
        end
    end
endmodule : sticky_bits

// file: hw/trap_control_unit.sv
// trap enable and trap status register with AHB-Lite access and interrupt
//
// Contract
// - accumulator A overflow traps when enable set
// - accumulator B overflow traps when enable set
// - address error sets its flag, else zero
// - stack error sets its flag, else zero
// - oscillator failure sets its flag, else zero
// - bit zero reads zero, ignores writes
`timescale 1ns/10ps
`include "trap_cfg.svh"
module trap_control_unit
    import trap_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire trap_evt_s TRAP_EVT,
    input wire logic OSC_FAIL_PIN,
    output logic MATH_TRAP,
    output logic IRQ
);

    // bus side state
    logic addr_ok;
    logic wr_pend_reg;
    logic rd_wait_reg;
    logic [`ADDR_DECODE_W-1:0] dp_addr_reg;
    logic [31:0] hrdata_reg;
    logic wr_tcs;
    logic wr_mask;
    logic rd_status;
    reg16_t rd_val;

    // register contents
    trap_en_s en_reg;
    logic [`FLAG_W-1:0] flags;
    logic [`FLAG_W-1:0] flag_clr;
    logic [`FLAG_W-1:0] flags_keep;
    logic [`FLAG_W-1:0] irq_status;
    logic [`FLAG_W-1:0] irq_clr;
    logic [`FLAG_W-1:0] irq_mask_reg;
    logic [`FLAG_W-1:0] evt;

    // trap causes
    logic ovf_trap;
    logic math_evt;
    logic math_trap_reg;
    logic osc_s2;
    logic osc_s3;
    logic osc_level_reg;
    logic osc_evt;

    // address phase accepted only while the block is clocked
    assign addr_ok = HSEL & HREADY & HTRANS[1] & CE;
    assign HREADYOUT = CE & ~rd_wait_reg;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_reg;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
        end else if (CE) begin
            wr_pend_reg <= addr_ok & HWRITE;
            rd_wait_reg <= addr_ok & ~HWRITE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            dp_addr_reg <= '0;
        end else if (CE && addr_ok) begin
            dp_addr_reg <= HADDR[`ADDR_DECODE_W-1:0];
        end
    end

    assign wr_tcs = wr_pend_reg & CE & (dp_addr_reg == `TCS1_OFFSET);
    assign wr_mask = wr_pend_reg & CE & (dp_addr_reg == `IRQ_MASK_OFFSET);
    assign rd_status = rd_wait_reg & CE & (dp_addr_reg == `IRQ_STATUS_OFFSET);

    // read mux; unmapped offsets and unused bits read zero
    always_comb begin
        rd_val = 16'h0000;
        unique case (dp_addr_reg)
            `TCS1_OFFSET: begin
                rd_val[`ACC_A_EN_BIT] = en_reg.acc_a_overflow_trap_en;
                rd_val[`ACC_B_EN_BIT] = en_reg.acc_b_overflow_trap_en;
                rd_val[`CAT_EN_BIT] = en_reg.catastrophic_overflow_trap_en;
                rd_val[`FLAG_MSB:`FLAG_LSB] = flags;
                rd_val[`UNUSED_BIT] = 1'b0;
            end
            `IRQ_STATUS_OFFSET: begin
                rd_val[`FLAG_MSB:`FLAG_LSB] = irq_status;
            end
            `IRQ_MASK_OFFSET: begin
                rd_val[`FLAG_MSB:`FLAG_LSB] = irq_mask_reg;
            end
            default: begin
                rd_val = 16'h0000;
            end
        endcase
    end

    // read data loaded in the single wait cycle, after any preceding write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            hrdata_reg <= `HRDATA_RESET;
        end else if (CE && rd_wait_reg) begin
            hrdata_reg <= {16'h0000, rd_val};
        end
    end

    // enables: plain read/write bits; bit zero has no storage
    always_ff @(posedge MCLK) begin
        if (RST) begin
            en_reg <= `TRAP_EN_RESET;
        end else if (wr_tcs) begin
            en_reg.acc_a_overflow_trap_en <= HWDATA[`ACC_A_EN_BIT];
            en_reg.acc_b_overflow_trap_en <= HWDATA[`ACC_B_EN_BIT];
            en_reg.catastrophic_overflow_trap_en <= HWDATA[`CAT_EN_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= HWDATA[`FLAG_MSB:`FLAG_LSB];
        end
    end

    // oscillator monitor runs outside this clock
    pin_sync3 #(
        .W(1)
    ) u_osc_sync (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .d(OSC_FAIL_PIN),
        .s2(osc_s2),
        .s3(osc_s3)
    );

    // a rise counts once the last two stages agree
    assign osc_evt = (osc_s2 == osc_s3) & osc_s3 & ~osc_level_reg;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            osc_level_reg <= 1'b0;
        end else if (CE && (osc_s2 == osc_s3)) begin
            osc_level_reg <= osc_s3;
        end
    end

    // overflow traps gated by their enables
    assign ovf_trap =
        (TRAP_EVT.acc_a_ovf & en_reg.acc_a_overflow_trap_en) |
        (TRAP_EVT.acc_b_ovf & en_reg.acc_b_overflow_trap_en) |
        ((TRAP_EVT.acc_a_cat_ovf | TRAP_EVT.acc_b_cat_ovf) &
         en_reg.catastrophic_overflow_trap_en);
    assign math_evt = ovf_trap | TRAP_EVT.div_zero_err | TRAP_EVT.shift_acc_err;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            math_trap_reg <= 1'b0;
        end else if (CE) begin
            math_trap_reg <= math_evt;
        end
    end
    assign MATH_TRAP = math_trap_reg;

    // event vector in flag layout
    always_comb begin
        evt = '0;
        evt[`SHIFT_ACC_BIT-`FLAG_LSB] = TRAP_EVT.shift_acc_err;
        evt[`DIV_ZERO_BIT-`FLAG_LSB] = TRAP_EVT.div_zero_err;
        evt[`DMA_ERR_BIT-`FLAG_LSB] = TRAP_EVT.dma_err;
        evt[`ARITH_ERR_BIT-`FLAG_LSB] = math_evt;
        evt[`ADDR_ERR_BIT-`FLAG_LSB] = TRAP_EVT.addr_err;
        evt[`STACK_ERR_BIT-`FLAG_LSB] = TRAP_EVT.stack_err;
        evt[`OSC_FAIL_BIT-`FLAG_LSB] = osc_evt;
    end

    // a written zero clears a flag, a written one leaves it
    assign flag_clr = wr_tcs ? ~HWDATA[`FLAG_MSB:`FLAG_LSB] : '0;
    assign flags_keep = flags & ~flag_clr;

    sticky_bits #(
        .W(`FLAG_W)
    ) u_flags (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .set(evt),
        .clr(flag_clr),
        .q(flags)
    );

    // interrupt status: a read clears the bits it returned
    assign irq_clr = rd_status ? irq_status : '0;

    sticky_bits #(
        .W(`FLAG_W)
    ) u_irq_status (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .set(evt),
        .clr(irq_clr),
        .q(irq_status)
    );

    assign IRQ = |(irq_status & irq_mask_reg);

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    a_acc_a_trap: assert property (
        (CE && TRAP_EVT.acc_a_ovf && en_reg.acc_a_overflow_trap_en) |=> MATH_TRAP
    ) else $error("enabled accumulator A overflow did not trap");

    a_acc_b_trap: assert property (
        (CE && TRAP_EVT.acc_b_ovf && en_reg.acc_b_overflow_trap_en) |=> MATH_TRAP
    ) else $error("enabled accumulator B overflow did not trap");

    a_acc_a_off: assert property (
        (CE && TRAP_EVT.acc_a_ovf && !en_reg.acc_a_overflow_trap_en && !TRAP_EVT.acc_b_ovf
            && !TRAP_EVT.acc_a_cat_ovf && !TRAP_EVT.acc_b_cat_ovf
            && !TRAP_EVT.div_zero_err && !TRAP_EVT.shift_acc_err) |=> !MATH_TRAP
    ) else $error("disabled accumulator A overflow trapped");

    a_cat_trap_on: assert property (
        (CE && (TRAP_EVT.acc_a_cat_ovf || TRAP_EVT.acc_b_cat_ovf)
            && en_reg.catastrophic_overflow_trap_en) |=> MATH_TRAP
    ) else $error("enabled catastrophic overflow did not trap");

    a_cat_trap_off: assert property (
        (CE && (TRAP_EVT.acc_a_cat_ovf || TRAP_EVT.acc_b_cat_ovf)
            && !en_reg.catastrophic_overflow_trap_en && !TRAP_EVT.acc_a_ovf
            && !TRAP_EVT.acc_b_ovf && !TRAP_EVT.div_zero_err
            && !TRAP_EVT.shift_acc_err) |=> !MATH_TRAP
    ) else $error("disabled catastrophic overflow trapped");

    a_addr_flag_set: assert property (
        (CE && TRAP_EVT.addr_err) |=> flags[`ADDR_ERR_BIT-`FLAG_LSB]
    ) else $error("address error flag not set");

    a_addr_flag_cause: assert property (
        $rose(flags[`ADDR_ERR_BIT-`FLAG_LSB]) |-> $past(TRAP_EVT.addr_err)
    ) else $error("address error flag set without cause");

    a_stack_flag_set: assert property (
        (CE && TRAP_EVT.stack_err) |=> flags[`STACK_ERR_BIT-`FLAG_LSB]
    ) else $error("stack error flag not set");

    a_stack_flag_cause: assert property (
        $rose(flags[`STACK_ERR_BIT-`FLAG_LSB]) |-> $past(TRAP_EVT.stack_err)
    ) else $error("stack error flag set without cause");

    a_osc_flag_set: assert property (
        (CE && osc_evt) |=> flags[`OSC_FAIL_BIT-`FLAG_LSB]
    ) else $error("oscillator failure flag not set");

    a_osc_flag_cause: assert property (
        $rose(flags[`OSC_FAIL_BIT-`FLAG_LSB]) |-> $past(osc_evt)
    ) else $error("oscillator failure flag set without cause");

    a_bit0_reads_zero: assert property (
        (rd_wait_reg && CE && dp_addr_reg == `TCS1_OFFSET)
            |=> (HRDATA[`UNUSED_BIT] == 1'b0) && (HRDATA[15:11] == 5'h00)
    ) else $error("unused bits of control register read nonzero");

    a_flags_sticky: assert property (
        CE |=> ((flags & $past(flags_keep)) == $past(flags_keep))
    ) else $error("trap flag dropped without a zero write");

    a_flag_zero_clears: assert property (
        (wr_tcs && !HWDATA[`STACK_ERR_BIT] && !TRAP_EVT.stack_err)
            |=> !flags[`STACK_ERR_BIT-`FLAG_LSB]
    ) else $error("zero write did not clear stack error flag");

    a_status_read_clear: assert property (
        (rd_status && evt == '0) |=> (irq_status == '0) && !IRQ
    ) else $error("status read did not clear interrupt bits");

    // a low enable leaves every register as it stood
    a_freeze_state: assert property (
        !CE |=> $stable(flags) && $stable(irq_status) && $stable(en_reg)
            && $stable(irq_mask_reg) && $stable(MATH_TRAP) && $stable(HRDATA)
    ) else $error("state changed while clock enable low");

    a_read_wait: assert property (
        (addr_ok && !HWRITE) |=> !HREADYOUT
    ) else $error("read answered without its wait cycle");

endmodule : trap_control_unit

// file: test/trap_control_unit_tb_top.sv
// self-checking bench for the trap control unit
`timescale 1ns/10ps
`include "trap_cfg.svh"
module trap_control_unit_tb_top
    import trap_pkg::*;
;
    logic mclk;
    logic rst;
    logic ce;
    logic hsel;
    logic hwrite;
    logic osc_fail_pin;
    logic hreadyout;
    logic hresp;
    logic math_trap;
    logic irq;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    trap_evt_s trap_evt;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    // per event: enable needed, flags expected, arithmetic trap expected
    logic [15:0] en_tab [9] = '{16'h0400, 16'h0200, 16'h0100, 16'h0100, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] fl_tab [9] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0090,
        16'h0050, 16'h0020, 16'h0008, 16'h0004};
    logic mt_tab [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    // single slave: its ready drives the bus ready
    trap_control_unit uut (.MCLK(mclk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .TRAP_EVT(trap_evt), .OSC_FAIL_PIN(osc_fail_pin), .MATH_TRAP(math_trap), .IRQ(irq));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task test_done;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] wd);
        @(posedge mclk);
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input string name, input logic [11:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(name, {16'h0000, e}, rd);
    endtask : rdchk

    // one-cycle cause, then the arithmetic trap must equal m for one cycle and be low the cycle after
    task automatic pulse(input trap_evt_s e, input logic m);
        @(posedge mclk);
        trap_evt <= e;
        @(posedge mclk);
        trap_evt <= '0;
        #1;
        chk("math trap", {31'h0, m}, {31'h0, math_trap});
        @(posedge mclk);
        #1;
        chk("math trap end", 32'h0, {31'h0, math_trap});
    endtask : pulse

    task automatic t_reset;
        rdchk("tcs1 reset", `TCS1_OFFSET, 16'h0000);
        rdchk("status reset", `IRQ_STATUS_OFFSET, 16'h0000);
        rdchk("mask reset", `IRQ_MASK_OFFSET, 16'h0000);
        chk("irq reset", 32'h0, {31'h0, irq});
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : t_reset

    task automatic t_unused_bits;
        bus(1'b1, `TCS1_OFFSET, 16'hFFFF);
        rdchk("tcs1 all ones", `TCS1_OFFSET, 16'h0700);
        bus(1'b1, 12'h00C, 16'hFFFF);
        rdchk("unmapped", 12'h00C, 16'h0000);
        bus(1'b1, `TCS1_OFFSET, 16'h0000);
        rdchk("tcs1 off", `TCS1_OFFSET, 16'h0000);
    endtask : t_unused_bits

    task automatic t_case(input int i);
        trap_evt_s ev;
        ev = trap_evt_s'(9'h100 >> i);
        if (i < 4) begin
            bus(1'b1, `TCS1_OFFSET, 16'h0700 & ~en_tab[i]);
            pulse(ev, 1'b0);
            rdchk("tcs1 disabled", `TCS1_OFFSET, 16'h0700 & ~en_tab[i]);
        end
        bus(1'b1, `TCS1_OFFSET, en_tab[i]);
        pulse(ev, mt_tab[i]);
        rdchk("tcs1 flag", `TCS1_OFFSET, en_tab[i] | fl_tab[i]);
        rdchk("tcs1 sticky", `TCS1_OFFSET, en_tab[i] | fl_tab[i]);
        rdchk("status", `IRQ_STATUS_OFFSET, fl_tab[i]);
        rdchk("status cleared", `IRQ_STATUS_OFFSET, 16'h0000);
        bus(1'b1, `TCS1_OFFSET, en_tab[i] | 16'h00FE);
        rdchk("tcs1 write one", `TCS1_OFFSET, en_tab[i] | fl_tab[i]);
        bus(1'b1, `TCS1_OFFSET, 16'h0000);
        rdchk("tcs1 cleared", `TCS1_OFFSET, 16'h0000);
    endtask : t_case

    task automatic t_osc;
        @(posedge mclk);
        osc_fail_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        osc_fail_pin <= 1'b0;
        repeat (6) @(posedge mclk);
        rdchk("osc flag", `TCS1_OFFSET, 16'h0002);
        rdchk("osc status", `IRQ_STATUS_OFFSET, 16'h0002);
        bus(1'b1, `TCS1_OFFSET, 16'h0000);
        rdchk("osc cleared", `TCS1_OFFSET, 16'h0000);
    endtask : t_osc

    task automatic t_irq;
        bus(1'b1, `IRQ_MASK_OFFSET, 16'hFFFF);
        rdchk("mask", `IRQ_MASK_OFFSET, 16'h00FE);
        pulse(trap_evt_s'(9'h002), 1'b0);
        chk("irq set", 32'h1, {31'h0, irq});
        rdchk("irq status", `IRQ_STATUS_OFFSET, 16'h0008);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b1, `IRQ_MASK_OFFSET, 16'h00F6);
        pulse(trap_evt_s'(9'h002), 1'b0);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdchk("masked status", `IRQ_STATUS_OFFSET, 16'h0008);
        bus(1'b1, `IRQ_MASK_OFFSET, 16'h0000);
        bus(1'b1, `TCS1_OFFSET, 16'h0000);
    endtask : t_irq

    // clock enable low freezes everything; a deselected write is ignored
    task automatic t_freeze;
        @(posedge mclk);
        ce <= 1'b0;
        trap_evt <= trap_evt_s'(9'h1FF);
        @(posedge mclk);
        trap_evt <= '0;
        #1;
        chk("ready frozen", 32'h0, {31'h0, hreadyout});
        chk("math frozen", 32'h0, {31'h0, math_trap});
        @(posedge mclk);
        ce <= 1'b1;
        hsel <= 1'b0;
        bus(1'b1, `TCS1_OFFSET, 16'h0700);
        hsel <= 1'b1;
        rdchk("tcs1 frozen", `TCS1_OFFSET, 16'h0000);
        rdchk("status frozen", `IRQ_STATUS_OFFSET, 16'h0000);
    endtask : t_freeze

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        trap_evt = '0;
        osc_fail_pin = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_unused_bits();
        for (int i = 0; i < 9; i++) begin
            t_case(i);
        end
        t_osc();
        t_irq();
        t_freeze();
        test_done();
    end
endmodule : trap_control_unit_tb_top
